/* File: src/sdram_cke_controller.sv */
// Controller end: drives CKE and commands, keeping the power-state timing.
module sdram_cke_controller
    import sdram_cke_pkg::*;
#(
    parameter int CNT_W     = 10,
    parameter int BURST_CK  = 4,
    parameter int TRP_CK    = 3,
    parameter int TRFC_CK   = 32,
    parameter int TMOD_CK   = 12,
    parameter int TZQ_CK    = 64,
    parameter int TCKE_CK   = 3,
    parameter int TXP_CK    = 3,
    parameter int TXS_CK    = 40,
    parameter int TXSDLL_CK = 512
) (
    input  wire logic          clock,
    input  wire logic          rstn,
    sdram_cke_if.controller    link,
    input  wire logic          cmd_valid,
    input  wire cmd_type       cmd,
    input  wire logic [BA_W-1:0] cmd_bank,
    input  wire logic          cmd_ap,
    output logic               cmd_taken,
    input  wire logic          pd_req,
    input  wire logic          sr_req,
    output logic               in_power_down,
    output logic               in_self_refresh
);

    // ------------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------------
    if (TXSDLL_CK >= 2**CNT_W || SR_WRITE_WAIT_CK >= 2**CNT_W || TZQ_CK >= 2**CNT_W ||
        TRFC_CK >= 2**CNT_W || TXS_CK >= 2**CNT_W || TCKE_CK < 2) begin : g_check
        $error("sdram_cke_controller: timing parameter does not fit the counters");
    end

    localparam logic [CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

    typedef enum logic [2:0] {
        c_run = 3'h1,
        c_pd  = 3'h2,
        c_sr  = 3'h4
    } ctl_state_type;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    ctl_state_type          state_reg;
    logic                   cke_reg;
    logic [3:0]             pins_reg;
    logic [BA_W-1:0]        ba_reg;
    logic                   a10_reg;
    logic                   taken_reg;
    logic [NUM_BANKS-1:0]   bank_reg;
    logic [CNT_W-1:0]       op_reg, mod_reg, hold_reg, exit_reg, dll_reg, wr_reg;
    logic                   kind_ok, take, go_pd, go_sr, go_exit, all_idle;

    // Commands are serialised: one operation finishes before the next one is taken.
    always_comb begin
        kind_ok = (exit_reg == CNT_ZERO) && (op_reg == CNT_ZERO) && (mod_reg == CNT_ZERO);
        if (cmd == cmd_rd && dll_reg != CNT_ZERO) kind_ok = 1'b0;
        if (cmd == cmd_wr && wr_reg != CNT_ZERO) kind_ok = 1'b0;
        if (cmd == cmd_act && bank_reg[cmd_bank]) kind_ok = 1'b0;
        if (cmd == cmd_ref && bank_reg != BANKS_NONE) kind_ok = 1'b0;
    end

    assign all_idle = (bank_reg == BANKS_NONE) && (op_reg == CNT_ZERO) && (mod_reg == CNT_ZERO) &&
                      (exit_reg == CNT_ZERO) && cke_reg;
    assign go_sr    = (state_reg == c_run) && sr_req && all_idle && (hold_reg == CNT_ZERO);
    assign go_pd    = (state_reg == c_run) && pd_req && !sr_req && cke_reg &&
                      (mod_reg == CNT_ZERO) && (exit_reg == CNT_ZERO) && (hold_reg == CNT_ZERO);
    assign go_exit  = (((state_reg == c_pd) && !pd_req) || ((state_reg == c_sr) && !sr_req)) &&
                      (hold_reg == CNT_ZERO);
    assign take     = (state_reg == c_run) && cmd_valid && !pd_req && !sr_req && kind_ok &&
                      (cmd != cmd_nop);

    // ------------------------------------------------------------------
    // Pins and power state
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_reg <= c_run;
            cke_reg   <= 1'b1;
            pins_reg  <= PINS_DES;
            ba_reg    <= '0;
            a10_reg   <= 1'b0;
            taken_reg <= 1'b0;
        end else begin
            pins_reg  <= PINS_DES;
            taken_reg <= 1'b0;
            case (state_reg)
                c_run: begin
                    if (go_sr) begin
                        cke_reg   <= 1'b0;
                        pins_reg  <= PINS_REF;
                        state_reg <= c_sr;
                    end else if (go_pd) begin
                        cke_reg   <= 1'b0;
                        pins_reg  <= PINS_NOP;
                        state_reg <= c_pd;
                    end else if (take) begin
                        pins_reg  <= encode_cmd(cmd);
                        ba_reg    <= cmd_bank;
                        a10_reg   <= cmd_ap;
                        taken_reg <= 1'b1;
                    end
                end
                default: begin
                    if (go_exit) begin
                        cke_reg   <= 1'b1;
                        pins_reg  <= PINS_NOP;
                        state_reg <= c_run;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Timers and bank tracking
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            hold_reg <= CNT_ZERO;
            exit_reg <= CNT_ZERO;
            dll_reg  <= CNT_ZERO;
            wr_reg   <= CNT_ZERO;
        end else begin
            hold_reg <= (hold_reg != CNT_ZERO) ? hold_reg - CNT_ONE : CNT_ZERO;
            exit_reg <= (exit_reg != CNT_ZERO) ? exit_reg - CNT_ONE : CNT_ZERO;
            dll_reg  <= (dll_reg  != CNT_ZERO) ? dll_reg  - CNT_ONE : CNT_ZERO;
            wr_reg   <= (wr_reg   != CNT_ZERO) ? wr_reg   - CNT_ONE : CNT_ZERO;
            if (go_sr || go_pd || go_exit) hold_reg <= CNT_W'(TCKE_CK - 1);
            if (go_exit && state_reg == c_pd) exit_reg <= CNT_W'(TXP_CK);
            if (go_exit && state_reg == c_sr) begin
                exit_reg <= CNT_W'(TXS_CK);
                dll_reg  <= CNT_W'(TXSDLL_CK);
                wr_reg   <= CNT_W'(SR_WRITE_WAIT_CK);
            end
        end
    end

    // Power-down performs no refresh, so refresh spacing stays with the user side.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            op_reg   <= CNT_ZERO;
            mod_reg  <= CNT_ZERO;
            bank_reg <= BANKS_NONE;
        end else begin
            op_reg  <= (op_reg  != CNT_ZERO) ? op_reg  - CNT_ONE : CNT_ZERO;
            mod_reg <= (mod_reg != CNT_ZERO) ? mod_reg - CNT_ONE : CNT_ZERO;
            if (take && !go_sr && !go_pd) begin
                case (cmd)
                    cmd_act: bank_reg <= bank_reg | bank_mask(cmd_bank);
                    cmd_rd, cmd_wr: begin
                        op_reg <= CNT_W'(BURST_CK);
                        if (cmd_ap) bank_reg <= bank_reg & ~bank_mask(cmd_bank);
                    end
                    cmd_pre: begin
                        op_reg   <= CNT_W'(TRP_CK);
                        bank_reg <= cmd_ap ? BANKS_NONE : (bank_reg & ~bank_mask(cmd_bank));
                    end
                    cmd_ref: op_reg  <= CNT_W'(TRFC_CK);
                    cmd_mrs: mod_reg <= CNT_W'(TMOD_CK);
                    cmd_zq:  op_reg  <= CNT_W'(TZQ_CK);
                    default: ;
                endcase
            end
        end
    end

    assign link.cke        = cke_reg;
    assign link.cmd_pins   = pins_reg;
    assign link.ba         = ba_reg;
    assign link.a10        = a10_reg;
    assign cmd_taken       = taken_reg;
    assign in_power_down   = (state_reg == c_pd);
    assign in_self_refresh = (state_reg == c_sr);

endmodule

/* File: src/sdram_cke_device.sv */
// SDRAM end: power-state tracking driven by CKE and the command pins.

// Summary of operation
// - No CKE low before tMRD and tMOD.
// - Transition from previous CKE, current CKE, command.
// - CKE low twice: hold state, ignore pins.
// - Power-down entry/exit only with NOP/deselect.
// - Self-refresh exit only with NOP/deselect.
// - Only NOP/deselect throughout tXS.
// - No read or termination before tXSDLL; odt_enabled is set again right after self-refresh exit.
// - No write before 512 cycles after exit.
// - Self refresh from idle: refresh with CKE falling.
// - Never enter self refresh during bursts.
// - Open banks plus falling CKE: active power-down.
// - Burst/precharge entry depends on banks afterwards.
// - Refreshing or idle entry: precharge power-down.
// - No refresh performed while powered down.
// - Hold new CKE level for tCKEmin.
// - Termination ignored; disabled in self refresh.
// - Idle: banks closed, CKE high, timers done.
// - Only listed state/command combinations are legal.
// - Commands decoded from pins at rising edge.
// - Deselect behaves exactly like no-operation.
// - Self-refresh exit taken from CKE level alone.
module sdram_cke_device
    import sdram_cke_pkg::*;
#(
    parameter int CNT_W    = 10,
    parameter int BURST_CK = 4,
    parameter int TRP_CK   = 3,
    parameter int TRFC_CK  = 32,
    parameter int TMOD_CK  = 12,
    parameter int TZQ_CK   = 64,
    parameter int TXP_CK   = 3,
    parameter int TXS_CK   = 40
) (
    input  wire logic          clock,
    input  wire logic          rstn,
    sdram_cke_if.device        link,
    output dev_state_type      power_state,
    output logic [NUM_BANKS-1:0] open_banks,
    output logic               idle,
    output logic               refresh_active,
    output logic               odt_enabled,
    output logic               illegal_cmd
);

    // ------------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------------
    if (CNT_W < 2 || TRFC_CK >= 2**CNT_W || TZQ_CK >= 2**CNT_W || TXS_CK >= 2**CNT_W ||
        BURST_CK < 1 || TRP_CK < 1 || TRFC_CK < 1 || TMOD_CK < 1 || TXP_CK < 1 || TXS_CK < 1) begin : g_check
        $error("sdram_cke_device: timing parameter does not fit the counters");
    end

    localparam logic [CNT_W-1:0] BURST_LD = CNT_W'(BURST_CK);
    localparam logic [CNT_W-1:0] TRP_LD   = CNT_W'(TRP_CK);
    localparam logic [CNT_W-1:0] TRFC_LD  = CNT_W'(TRFC_CK);
    localparam logic [CNT_W-1:0] TMOD_LD  = CNT_W'(TMOD_CK);
    localparam logic [CNT_W-1:0] TZQ_LD   = CNT_W'(TZQ_CK);
    localparam logic [CNT_W-1:0] TXP_LD   = CNT_W'(TXP_CK);
    localparam logic [CNT_W-1:0] TXS_LD   = CNT_W'(TXS_CK);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    dev_state_type          state_reg,   state_next;
    logic                   cke_prev_reg;
    logic [NUM_BANKS-1:0]   bank_reg,    bank_next;
    logic [NUM_BANKS-1:0]   closing_reg, closing_next;
    logic [CNT_W-1:0]       busy_reg,    busy_next;
    logic [CNT_W-1:0]       ref_reg,     ref_next;
    logic [CNT_W-1:0]       misc_reg,    misc_next;
    logic [CNT_W-1:0]       exit_reg,    exit_next;
    logic                   idle_reg,    idle_next;
    logic                   illegal_reg, illegal_next;
    logic                   refresh_reg, odt_reg;
    cmd_type                cmd;
    logic                   idle_now;

    // The link is driven from the same clock, so the pins are used without synchronisers.
    assign cmd      = decode_cmd(link.cmd_pins);
    assign idle_now = (state_reg == st_idle) && (exit_reg == CNT_ZERO) &&
                      (misc_reg == CNT_ZERO) && cke_prev_reg;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        state_next   = state_reg;
        bank_next    = bank_reg;
        closing_next = closing_reg;
        illegal_next = 1'b0;
        busy_next    = (busy_reg != CNT_ZERO) ? busy_reg - CNT_ONE : CNT_ZERO;
        ref_next     = (ref_reg  != CNT_ZERO) ? ref_reg  - CNT_ONE : CNT_ZERO;
        misc_next    = (misc_reg != CNT_ZERO) ? misc_reg - CNT_ONE : CNT_ZERO;
        exit_next    = (exit_reg != CNT_ZERO) ? exit_reg - CNT_ONE : CNT_ZERO;
        // A burst or precharge that was running at power-down entry still finishes inside.
        if (busy_reg == CNT_ONE) begin
            bank_next    = bank_reg & ~closing_reg;
            closing_next = BANKS_NONE;
        end
        case (state_reg)
            st_act_pd, st_pre_pd: begin
                if (link.cke) begin
                    state_next = (bank_next != BANKS_NONE) ? st_active : st_idle;
                    exit_next  = TXP_LD;
                    if (cmd != cmd_nop) illegal_next = 1'b1;
                end
            end
            st_self_refresh: begin
                if (link.cke) begin
                    state_next = st_idle;
                    exit_next  = TXS_LD;
                end
            end
            default: begin
                if (cke_prev_reg && !link.cke) begin
                    if (cmd == cmd_ref && idle_now) begin
                        state_next = st_self_refresh;
                    end else if (cmd == cmd_nop) begin
                        if (state_reg == st_active) begin
                            state_next = st_act_pd;
                        end else if (state_reg == st_busy) begin
                            state_next = ((bank_reg & ~closing_reg) != BANKS_NONE) ?
                                         st_act_pd : st_pre_pd;
                        end else begin
                            state_next = st_pre_pd;
                        end
                    end else begin
                        illegal_next = 1'b1;
                    end
                end else begin
                    if (cmd != cmd_nop && (exit_reg != CNT_ZERO || !link.cke)) begin
                        illegal_next = 1'b1;
                    end
                    case (cmd)
                        cmd_act: bank_next = bank_next | bank_mask(link.ba);
                        cmd_rd, cmd_wr: begin
                            busy_next = BURST_LD;
                            if (link.a10) closing_next = closing_next | bank_mask(link.ba);
                        end
                        cmd_pre: begin
                            busy_next    = TRP_LD;
                            closing_next = link.a10 ? BANKS_ALL : (closing_next | bank_mask(link.ba));
                        end
                        cmd_ref: ref_next  = TRFC_LD;
                        cmd_mrs: misc_next = TMOD_LD;
                        cmd_zq:  misc_next = TZQ_LD;
                        default: ;
                    endcase
                    if (ref_next != CNT_ZERO) state_next = st_refreshing;
                    else if (busy_next != CNT_ZERO) state_next = st_busy;
                    else if (bank_next != BANKS_NONE) state_next = st_active;
                    else state_next = st_idle;
                end
            end
        endcase
        idle_next = (state_next == st_idle) && link.cke &&
                    (exit_next == CNT_ZERO) && (misc_next == CNT_ZERO);
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cke_prev_reg <= 1'b0;
        end else begin
            cke_prev_reg <= link.cke;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_reg   <= st_idle;
            bank_reg    <= BANKS_NONE;
            closing_reg <= BANKS_NONE;
            busy_reg    <= CNT_ZERO;
            misc_reg    <= CNT_ZERO;
            exit_reg    <= CNT_ZERO;
        end else begin
            state_reg   <= state_next;
            bank_reg    <= bank_next;
            closing_reg <= closing_next;
            busy_reg    <= busy_next;
            misc_reg    <= misc_next;
            exit_reg    <= exit_next;
        end
    end

    // A refresh started before power-down finishes, but no new one is ever begun inside it.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ref_reg     <= CNT_ZERO;
            refresh_reg <= 1'b0;
        end else begin
            ref_reg     <= ref_next;
            refresh_reg <= (state_next == st_self_refresh) ||
                           (state_next == st_refreshing);
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            idle_reg    <= 1'b0;
            illegal_reg <= 1'b0;
            odt_reg     <= 1'b0;
        end else begin
            idle_reg    <= idle_next;
            illegal_reg <= illegal_next;
            odt_reg     <= (state_next != st_self_refresh);
        end
    end

    assign power_state    = state_reg;
    assign open_banks     = bank_reg;
    assign idle           = idle_reg;
    assign refresh_active = refresh_reg;
    assign odt_enabled    = odt_reg;
    assign illegal_cmd    = illegal_reg;

endmodule

/* File: src/sdram_cke_if.sv */
// Pin-level link between the memory controller and the SDRAM power-state logic.
interface sdram_cke_if;
    logic       cke;
    logic [3:0] cmd_pins;
    logic [2:0] ba;
    logic       a10;

    modport controller (output cke, output cmd_pins, output ba, output a10);
    modport device     (input cke, input cmd_pins, input ba, input a10);
endinterface

/* File: src/sdram_cke_pkg.sv */
// Shared constants, command encodings and state types for the CKE power-state link.
package sdram_cke_pkg;

    // ------------------------------------------------------------------
    // Geometry and fixed timing
    // ------------------------------------------------------------------
    localparam int          BA_W             = 3;
    localparam int          NUM_BANKS        = 8;
    localparam int          SR_WRITE_WAIT_CK = 512;
    localparam logic [7:0]  BANKS_NONE       = 8'h00;
    localparam logic [7:0]  BANKS_ALL        = 8'hFF;

    // ------------------------------------------------------------------
    // Pin patterns {cs_n, ras_n, cas_n, we_n}
    // ------------------------------------------------------------------
    localparam logic [3:0]  PINS_MRS = 4'h0;
    localparam logic [3:0]  PINS_REF = 4'h1;
    localparam logic [3:0]  PINS_PRE = 4'h2;
    localparam logic [3:0]  PINS_ACT = 4'h3;
    localparam logic [3:0]  PINS_WR  = 4'h4;
    localparam logic [3:0]  PINS_RD  = 4'h5;
    localparam logic [3:0]  PINS_ZQ  = 4'h6;
    localparam logic [3:0]  PINS_NOP = 4'h7;
    localparam logic [3:0]  PINS_DES = 4'hF;

    typedef enum logic [2:0] {
        cmd_nop = 3'h0,
        cmd_mrs = 3'h1,
        cmd_ref = 3'h2,
        cmd_act = 3'h3,
        cmd_pre = 3'h4,
        cmd_wr  = 3'h5,
        cmd_rd  = 3'h6,
        cmd_zq  = 3'h7
    } cmd_type;

    typedef enum logic [6:0] {
        st_idle         = 7'h01,
        st_active       = 7'h02,
        st_busy         = 7'h04,
        st_refreshing   = 7'h08,
        st_act_pd       = 7'h10,
        st_pre_pd       = 7'h20,
        st_self_refresh = 7'h40
    } dev_state_type;

    // Deselect folds into the no-operation code: neither starts or stops anything.
    function automatic cmd_type decode_cmd(input logic [3:0] pins);
        cmd_type c;
        c = cmd_nop;
        if (pins[3]) c = cmd_nop;
        else if (pins == PINS_MRS) c = cmd_mrs;
        else if (pins == PINS_REF) c = cmd_ref;
        else if (pins == PINS_PRE) c = cmd_pre;
        else if (pins == PINS_ACT) c = cmd_act;
        else if (pins == PINS_WR)  c = cmd_wr;
        else if (pins == PINS_RD)  c = cmd_rd;
        else if (pins == PINS_ZQ)  c = cmd_zq;
        return c;
    endfunction

    function automatic logic [3:0] encode_cmd(input cmd_type c);
        logic [3:0] p;
        p = PINS_DES;
        case (c)
            cmd_mrs: p = PINS_MRS;
            cmd_ref: p = PINS_REF;
            cmd_pre: p = PINS_PRE;
            cmd_act: p = PINS_ACT;
            cmd_wr:  p = PINS_WR;
            cmd_rd:  p = PINS_RD;
            cmd_zq:  p = PINS_ZQ;
            default: p = PINS_NOP;
        endcase
        return p;
    endfunction

    function automatic logic [7:0] bank_mask(input logic [2:0] ba);
        return 8'h01 << ba;
    endfunction

endpackage

/* File: tb/sdram_cke_asserts.sv */
// Assertions on the CKE and command pins between the controller and the device.
module sdram_cke_asserts
    import sdram_cke_pkg::*;
#(
    parameter int TXS_CK    = 40,
    parameter int TXSDLL_CK = 512
) (
    input wire logic       clock,
    input wire logic       rstn,
    input wire logic       cke,
    input wire logic [3:0] cmd_pins
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        sr_reg;
    logic [10:0] since_reg;
    wire         quiet = cmd_pins[3] || cmd_pins == PINS_NOP;
    default clocking dc @(posedge clock); endclocking
    default disable iff (!rstn);
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) sr_reg <= 1'b0;
        else if ($fell(cke)) sr_reg <= cmd_pins == PINS_REF;
    end
    // Saturates, so a long idle stretch can never wrap back into the exit window.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) since_reg <= 11'h7FF;
        else if ($rose(cke) && sr_reg) since_reg <= 11'h000;
        else if (since_reg != 11'h7FF) since_reg <= since_reg + 11'h001;
    end
    a_entry_cmd_quiet: assert property ($fell(cke) |-> quiet || cmd_pins == PINS_REF)
        else $error("bad command at cke fall");
    a_exit_cmd_quiet: assert property ($rose(cke) |-> quiet)
        else $error("bad command at cke rise");
    a_high_cke_held: assert property ($rose(cke) |=> cke [*2])
        else $error("cke high too short");
    a_low_cke_held: assert property ($fell(cke) |=> !cke [*2])
        else $error("cke low too short");
    a_mrs_keeps_awake: assert property (cmd_pins == PINS_MRS |=> cke [*8])
        else $error("cke low too soon after mode set");
    a_exit_only_quiet: assert property (cke && since_reg < TXS_CK - 1 |-> quiet)
        else $error("command inside exit period");
    a_read_after_lock: assert property (cmd_pins == PINS_RD |-> since_reg >= TXSDLL_CK - 1)
        else $error("read too soon after exit");
    a_write_after_wait: assert property (cmd_pins == PINS_WR |-> since_reg >= SR_WRITE_WAIT_CK - 1)
        else $error("write too soon after exit");
    c_sr_exit: cover property (sr_reg && $rose(cke));
    c_pd_entry: cover property ($fell(cke) && cmd_pins == PINS_NOP);
    c_read: cover property (cmd_pins == PINS_RD);
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench joining controller and device through the pin interface.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import sdram_cke_pkg::*;
    logic clock = 0, rstn = 0, cmd_valid = 0, cmd_ap = 0, pd_req = 0, sr_req = 0, bad_seen = 0;
    logic cmd_taken, in_power_down, in_self_refresh, idle, refresh_active, odt_enabled, illegal_cmd;
    logic [2:0] cmd_bank = 3'h0;
    logic [7:0] open_banks;
    cmd_type cmd = cmd_nop;
    dev_state_type power_state;
    int num_errors = 0, checked = 0;
    sdram_cke_if sdram_cke_if_i ();
    sdram_cke_controller #(.TXSDLL_CK(16)) sdram_cke_controller_i (.clock(clock), .rstn(rstn),
        .link(sdram_cke_if_i.controller), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_bank(cmd_bank), .cmd_ap(cmd_ap),
        .cmd_taken(cmd_taken), .pd_req(pd_req), .sr_req(sr_req), .in_power_down(in_power_down),
        .in_self_refresh(in_self_refresh));
    sdram_cke_device sdram_cke_device_i (.clock(clock), .rstn(rstn), .link(sdram_cke_if_i.device),
        .power_state(power_state), .open_banks(open_banks), .idle(idle), .refresh_active(refresh_active),
        .odt_enabled(odt_enabled), .illegal_cmd(illegal_cmd));
    sdram_cke_asserts #(.TXS_CK(40), .TXSDLL_CK(16)) sdram_cke_asserts_i (.clock(clock), .rstn(rstn),
        .cke(sdram_cke_if_i.cke), .cmd_pins(sdram_cke_if_i.cmd_pins));
    always #2.5 clock = ~clock;
    always @(posedge clock) if (illegal_cmd === 1'b1) bad_seen <= 1'b1;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic op(input cmd_type c, input logic [2:0] b, input logic ap);
        int i;
        i = 0;
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd <= c;
        cmd_bank <= b;
        cmd_ap <= ap;
        do begin @(negedge clock); i++; end while (cmd_taken !== 1'b1 && i < 2000);
        check(cmd_taken, 1'b1);
        @(posedge clock);
        cmd_valid <= 1'b0;
        @(negedge clock);
    endtask
    // Both request levels move together; the wait ends once the combined flag agrees.
    task automatic pwr(input logic pd, input logic sr);
        int i;
        i = 0;
        @(posedge clock);
        pd_req <= pd;
        sr_req <= sr;
        do begin @(negedge clock); i++; end while ((in_power_down | in_self_refresh) !== (pd | sr) && i < 200);
        check(in_power_down | in_self_refresh, pd | sr);
        @(negedge clock);
    endtask
    task automatic results;
        if (num_errors == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        repeat (2) @(negedge clock);
        check(idle, 1'b1);
        op(cmd_mrs, 3'h0, 1'b0);
        op(cmd_ref, 3'h0, 1'b0);
        check(refresh_active, 1'b1);
        pwr(1'b1, 1'b0);
        check(power_state, st_pre_pd);
        check(refresh_active, 1'b0);
        pwr(1'b0, 1'b0);
        op(cmd_act, 3'h2, 1'b0);
        check(open_banks, 8'h04);
        pwr(1'b1, 1'b0);
        check(power_state, st_act_pd);
        check(refresh_active, 1'b0);
        pwr(1'b0, 1'b0);
        check(power_state, st_active);
        op(cmd_pre, 3'h0, 1'b1);
        op(cmd_zq, 3'h0, 1'b0);
        check(idle, 1'b0);
        pwr(1'b0, 1'b1);
        check(power_state, st_self_refresh);
        check(refresh_active, 1'b1);
        check(odt_enabled, 1'b0);
        pwr(1'b0, 1'b0);
        check(odt_enabled, 1'b1);
        check(idle, 1'b0);
        op(cmd_act, 3'h1, 1'b0);
        op(cmd_wr, 3'h1, 1'b0);
        op(cmd_rd, 3'h1, 1'b1);
        pwr(1'b1, 1'b0);
        check(power_state, st_pre_pd);
        pwr(1'b0, 1'b0);
        check(bad_seen, 1'b0);
        results();
    end
    initial begin
        #50us;
        num_errors++;
        results();
    end
endmodule
